// ==== dv/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] mode;
        logic [3:0] refc;
        logic [16:0] val;
        logic [15:0] lo;
        logic [15:0] hi;
        logic up;
    } tpd_row_s;
    tpd_row_s rows [8] = '{
        '{2'h1, 4'h7, 17'h1ffff, 16'h00c8, 16'h0000, 1'b1},
        '{2'h1, 4'h2, 17'h00040, 16'h00c8, 16'h0000, 1'b0},
        '{2'h3, 4'h3, 17'h00040, 16'h00c8, 16'h0000, 1'b0},
        '{2'h3, 4'h6, 17'h1ffff, 16'h00c8, 16'h0000, 1'b1},
        '{2'h2, 4'h8, 17'h00040, 16'h0000, 16'h00c8, 1'b0},
        '{2'h2, 4'h9, 17'h00040, 16'h0000, 16'h00c8, 1'b0},
        '{2'h2, 4'h7, 17'h00040, 16'h00c8, 16'h0000, 1'b1},
        '{2'h1, 4'hc, 17'h00040, 16'h00c8, 16'h0000, 1'b0}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] lo_half = 16'h0000;
    logic [15:0] hi_half = 16'h0000;
    logic [7:0] rdata;
    logic [6:0] seen;
    logic len, hen, up_n, dn_n, vo, voe, co, coe, xtal, lo_osc, hi_osc;
    int bad_count = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    tpd_synth i_tpd_synth (.clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .xtal_in(xtal), .low_band_osc_in(lo_osc), .high_band_osc_in(hi_osc),
        .low_band_in_en(len), .high_band_in_en(hen), .up_request_n(up_n),
        .down_request_n(dn_n), .voltage_error_out_o(vo), .voltage_error_out_oe(voe),
        .current_error_out_o(co), .current_error_out_oe(coe));
    tpd_vco_model i_tpd_vco_model (.lo_half, .hi_half, .xtal_in(xtal),
        .low_band_osc_in(lo_osc), .high_band_osc_in(hi_osc));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            bad_count++;
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task automatic watch(input int n);
        seen = 7'h00;
        // Let the last write reach the registered pins first
        @(posedge clk);
        repeat (n) begin
            @(negedge clk);
            seen |= {hen, len, voe & vo, coe, voe, !dn_n, !up_n};
        end
    endtask
    task automatic load(input logic [16:0] v);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_LO, v[8:1]);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_HI, v[16:9]);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_THIRD, {v[0], 7'h00});
        wr_reg(tpd_pkg::TPD_ADDR_LOAD, 8'h01);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #4000000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(tpd_pkg::TPD_ADDR_REF, 8'h0f);
        rd_chk(tpd_pkg::TPD_ADDR_UNLOCK, 8'h00);
        wr_reg(16'hffa8, 8'hff);
        rd_chk(16'hffa8, 8'h00);
        wr_reg(tpd_pkg::TPD_ADDR_MODE, 8'hff);
        rd_chk(tpd_pkg::TPD_ADDR_MODE, 8'h03);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_THIRD, 8'hff);
        rd_chk(tpd_pkg::TPD_ADDR_DIV_THIRD, 8'h80);
        wr_reg(tpd_pkg::TPD_ADDR_EOCFG, 8'h02);
        rd_chk(tpd_pkg::TPD_ADDR_EOCFG, 8'h02);
        rd_chk(tpd_pkg::TPD_ADDR_LOAD, 8'h00);
        wr_reg(tpd_pkg::TPD_ADDR_EOCFG, 8'h00);
        $display("regs done");
        foreach (rows[i]) begin
            lo_half <= rows[i].lo;
            hi_half <= rows[i].hi;
            wr_reg(tpd_pkg::TPD_ADDR_MODE, {6'h00, rows[i].mode});
            wr_reg(tpd_pkg::TPD_ADDR_REF, {4'h0, rows[i].refc});
            load(rows[i].val);
            watch(2200);
            watch(2200);
            chk({7'h00, rows[i].up ? seen[0] : seen[1]}, 8'h01);
            if (rows[i].up) rd_chk(tpd_pkg::TPD_ADDR_UNLOCK, 8'h01);
            $display("row %0d done", i);
        end
        wr_reg(tpd_pkg::TPD_ADDR_REF, 8'h07);
        load(17'h1ffff);
        watch(2200);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_LO, 8'h20);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_HI, 8'h00);
        wr_reg(tpd_pkg::TPD_ADDR_DIV_THIRD, 8'h00);
        watch(2200);
        chk({6'h00, seen[1:0]}, 8'h01);
        wr_reg(tpd_pkg::TPD_ADDR_LOAD, 8'h01);
        watch(2200);
        watch(2200);
        chk({7'h00, seen[1]}, 8'h01);
        $display("load done");
        wr_reg(tpd_pkg::TPD_ADDR_EOCFG, 8'h02);
        watch(2200);
        chk({5'h00, seen[4:2]}, 8'h05);
        wr_reg(tpd_pkg::TPD_ADDR_EOCFG, 8'h00);
        watch(2200);
        chk({5'h00, seen[4:2]}, 8'h07);
        wr_reg(tpd_pkg::TPD_ADDR_MODE, 8'h00);
        watch(200);
        watch(2200);
        chk({1'b0, seen} & 8'h74, 8'h04);
        $display("pins done");
        wr_reg(tpd_pkg::TPD_ADDR_REF, 8'h0f);
        watch(200);
        watch(2200);
        chk({1'b0, seen}, 8'h00);
        rd_chk(tpd_pkg::TPD_ADDR_UNLOCK, 8'h01);
        watch(600);
        rd_chk(tpd_pkg::TPD_ADDR_UNLOCK, 8'h00);
        wr_reg(tpd_pkg::TPD_ADDR_MODE, 8'h01);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(tpd_pkg::TPD_ADDR_MODE, 8'h00);
        $display("reset done");
        final_report();
    end
endmodule
bind tpd_synth tpd_synth_checker i_tpd_synth_checker (.*);

// ==== dv/tpd_synth_checker.sv ====
module tpd_synth_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Oscillator and crystal inputs
    input wire logic xtal_in,
    input wire logic low_band_osc_in,
    input wire logic high_band_osc_in,
    // Enables, requests, error pins
    input wire logic low_band_in_en,
    input wire logic high_band_in_en,
    input wire logic up_request_n,
    input wire logic down_request_n,
    input wire logic voltage_error_out_o,
    input wire logic voltage_error_out_oe,
    input wire logic current_error_out_o,
    input wire logic current_error_out_oe
);
    localparam logic [15:0] REF_OK = 16'h13cc;
    logic [1:0] mode_q;
    logic [3:0] ref_q;
    logic [2:0] cfg_cnt;
    logic float_q, quiet_rd, cfg_wr;
    assign cfg_wr = wr && addr >= tpd_pkg::TPD_ADDR_MODE && addr <= tpd_pkg::TPD_ADDR_EOCFG;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= tpd_pkg::TPD_MODE_RST;
            ref_q <= tpd_pkg::TPD_REF_RST;
            float_q <= 1'b0;
            cfg_cnt <= 3'h0;
            quiet_rd <= 1'b0;
        end else begin
            if (wr && addr == tpd_pkg::TPD_ADDR_MODE) mode_q <= wdata[1:0];
            if (wr && addr == tpd_pkg::TPD_ADDR_REF) ref_q <= wdata[3:0];
            if (wr && addr == tpd_pkg::TPD_ADDR_EOCFG) float_q <= wdata[1];
            cfg_cnt <= cfg_wr ? 3'h0 : cfg_cnt + {2'h0, cfg_cnt != 3'h7};
            quiet_rd <= !REF_OK[ref_q] && (quiet_rd || (rd && cfg_cnt == 3'h7 &&
                addr == tpd_pkg::TPD_ADDR_UNLOCK));
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_settled;
        cfg_cnt == 3'h7;
    endsequence
    sequence s_unlock_rd;
        rd && addr == tpd_pkg::TPD_ADDR_UNLOCK;
    endsequence
    chk_float_hiz: assert property (float_q && $past(float_q) |-> !current_error_out_oe)
        else $error("current pin driven");
    chk_pins_same: assert property (s_settled ##0 !float_q |->
        current_error_out_oe == voltage_error_out_oe &&
        (!voltage_error_out_oe || current_error_out_o == voltage_error_out_o))
        else $error("error pins differ");
    chk_up_low: assert property ($fell(up_request_n) |->
        ##[0:1] voltage_error_out_oe && !voltage_error_out_o)
        else $error("up pin not low");
    chk_down_high: assert property ($fell(down_request_n) |->
        ##[0:1] voltage_error_out_oe && voltage_error_out_o)
        else $error("down pin not high");
    chk_req_excl: assert property (up_request_n || down_request_n)
        else $error("both requests active");
    chk_disabled_quiet: assert property (s_settled ##0 !REF_OK[ref_q] |->
        up_request_n && down_request_n && !voltage_error_out_oe && !current_error_out_oe &&
        !low_band_in_en && !high_band_in_en)
        else $error("activity while disabled");
    chk_band_select: assert property (s_settled ##0 REF_OK[ref_q] |->
        low_band_in_en == mode_q[0] && high_band_in_en == (mode_q == 2'h2))
        else $error("wrong input enabled");
    chk_off_low: assert property (s_settled ##0 REF_OK[ref_q] && mode_q == 2'h0 |->
        voltage_error_out_oe && !voltage_error_out_o)
        else $error("mode off pin not low");
    chk_unlock_upper: assert property (s_unlock_rd |=> rdata[7:1] == 7'h00)
        else $error("unlock upper bits set");
    chk_unlock_clear: assert property (quiet_rd ##0 s_unlock_rd |=> !rdata[0])
        else $error("unlock flag not cleared");
endmodule

// ==== dv/tpd_vco_model.sv ====
module tpd_vco_model (
    // Half periods, 0 stops
    input wire logic [15:0] lo_half,
    input wire logic [15:0] hi_half,
    // Oscillator outputs
    output logic xtal_in,
    output logic low_band_osc_in,
    output logic high_band_osc_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial xtal_in = 1'b0;
    always #111 xtal_in = ~xtal_in;
    always begin
        if (lo_half != 16'h0) begin
            #(lo_half) low_band_osc_in = ~low_band_osc_in;
        end else begin
            low_band_osc_in = 1'b0;
            #40;
        end
    end
    always begin
        if (hi_half != 16'h0) begin
            #(hi_half) high_band_osc_in = ~high_band_osc_in;
        end else begin
            high_band_osc_in = 1'b0;
            #40;
        end
    end
endmodule

// ==== hw/tpd_div_if.sv ====
interface tpd_div_if;
    logic enable;
    logic swallow_mode;
    logic load;
    logic [11:0] prog_val;
    logic [4:0] swal_val;
    logic in_edge;
    logic fn_tick;

    modport ctrl (output enable, output swallow_mode, output load, output prog_val,
        output swal_val, output in_edge, input fn_tick);
    modport div (input enable, input swallow_mode, input load, input prog_val,
        input swal_val, input in_edge, output fn_tick);
endinterface

// ==== hw/tpd_divider.sv ====
module tpd_divider (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    tpd_div_if.div d
);
    logic [11:0] prog_val, next_prog_val;
    logic [4:0] swal_val, next_swal_val;
    logic [11:0] prog_cnt, next_prog_cnt;
    logic [4:0] swal_cnt, next_swal_cnt;
    logic [5:0] pre_cnt, next_pre_cnt;
    logic fn_tick, next_fn_tick;
    logic [5:0] modulus;

    always_comb begin
        next_prog_val = prog_val;
        next_swal_val = swal_val;
        next_prog_cnt = prog_cnt;
        next_swal_cnt = swal_cnt;
        next_pre_cnt = pre_cnt;
        next_fn_tick = 1'b0;
        // Higher modulus while swallow count remains [R25]
        modulus = (swal_cnt != 5'h00) ? tpd_pkg::TPD_PRESCALE_LOW + 6'h01
            : tpd_pkg::TPD_PRESCALE_LOW;
        if (d.load) begin
            // New value takes effect only on transfer [R5] [R17]
            next_prog_val = d.prog_val;
            next_swal_val = d.swallow_mode ? d.swal_val : 5'h00;
            next_prog_cnt = d.prog_val;
            next_swal_cnt = d.swallow_mode ? d.swal_val : 5'h00;
            next_pre_cnt = 6'h00;
        end else if (!d.enable || prog_val == 12'h000) begin
            next_pre_cnt = 6'h00;
        end else if (d.in_edge) begin
            if (!d.swallow_mode) begin
                // Direct division by the programmable counter [R17]
                if (prog_cnt <= 12'h001) begin
                    next_prog_cnt = prog_val;
                    next_fn_tick = 1'b1;
                end else begin
                    next_prog_cnt = prog_cnt - 12'h001;
                end
            end else if (pre_cnt == modulus - 6'h01) begin
                // 32 * prog + swallow input pulses per output [R4] [R20]
                next_pre_cnt = 6'h00;
                if (swal_cnt != 5'h00) begin
                    next_swal_cnt = swal_cnt - 5'h01;
                end
                if (prog_cnt <= 12'h001) begin
                    next_prog_cnt = prog_val;
                    next_swal_cnt = swal_val;
                    next_fn_tick = 1'b1;
                end else begin
                    next_prog_cnt = prog_cnt - 12'h001;
                end
            end else begin
                next_pre_cnt = pre_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_val <= 12'h000;
            swal_val <= 5'h00;
            prog_cnt <= 12'h000;
            swal_cnt <= 5'h00;
            pre_cnt <= 6'h00;
            fn_tick <= 1'b0;
        end else begin
            prog_val <= next_prog_val;
            swal_val <= next_swal_val;
            prog_cnt <= next_prog_cnt;
            swal_cnt <= next_swal_cnt;
            pre_cnt <= next_pre_cnt;
            fn_tick <= next_fn_tick;
        end
    end

    assign d.fn_tick = fn_tick;
endmodule

// ==== hw/tpd_pkg.sv ====
package tpd_pkg;
    // Register map, byte addresses on the 16-bit register port
    localparam logic [15:0] TPD_ADDR_MODE = 16'hffa0;
    localparam logic [15:0] TPD_ADDR_REF = 16'hffa1;
    localparam logic [15:0] TPD_ADDR_UNLOCK = 16'hffa2;
    localparam logic [15:0] TPD_ADDR_LOAD = 16'hffa3;
    localparam logic [15:0] TPD_ADDR_EOCFG = 16'hffa4;
    localparam logic [15:0] TPD_ADDR_DIV_LO = 16'hffa5;
    localparam logic [15:0] TPD_ADDR_DIV_HI = 16'hffa6;
    localparam logic [15:0] TPD_ADDR_DIV_THIRD = 16'hffa7;

    // Values after reset
    localparam logic [1:0] TPD_MODE_RST = 2'h0;
    localparam logic [3:0] TPD_REF_RST = 4'hf;
    localparam logic [1:0] TPD_EOCFG_RST = 2'h0;
    localparam logic [7:0] TPD_BYTE_RST = 8'h00;

    // Field positions
    localparam int TPD_LSB_POS = 7;
    localparam int TPD_FLOAT_POS = 1;
    localparam int TPD_REGCUR_POS = 0;
    localparam int TPD_LOAD_POS = 0;
    localparam int TPD_UNLOCK_POS = 0;

    // Counter widths and prescaler modulus
    localparam int TPD_PROG_W = 12;
    localparam int TPD_SWAL_W = 5;
    localparam logic [5:0] TPD_PRESCALE_LOW = 6'h20;

    // Reference divisors, in crystal cycles
    localparam int TPD_XTAL_KHZ = 4500;
    localparam int TPD_CLK_KHZ = 25000;
    localparam logic [12:0] TPD_DIV_1K = 13'(TPD_XTAL_KHZ / 1);
    localparam logic [12:0] TPD_DIV_3K = 13'(TPD_XTAL_KHZ / 3);
    localparam logic [12:0] TPD_DIV_5K = 13'(TPD_XTAL_KHZ / 5);
    localparam logic [12:0] TPD_DIV_9K = 13'(TPD_XTAL_KHZ / 9);
    localparam logic [12:0] TPD_DIV_10K = 13'(TPD_XTAL_KHZ / 10);
    localparam logic [12:0] TPD_DIV_25K = 13'(TPD_XTAL_KHZ / 25);
    localparam logic [12:0] TPD_DIV_50K = 13'(TPD_XTAL_KHZ / 50);

    typedef enum logic [1:0] {
        TPD_MODE_OFF = 2'b00,
        TPD_MODE_DIRECT = 2'b01,
        TPD_MODE_SW_HIGH = 2'b10,
        TPD_MODE_SW_LOW = 2'b11
    } tpd_mode_e;

    typedef enum logic [1:0] {
        TPD_PFD_IDLE = 2'b00,
        TPD_PFD_UP = 2'b01,
        TPD_PFD_DN = 2'b10
    } tpd_pfd_e;
endpackage

// ==== hw/tpd_synth.sv ====
// Contract
// R1 - Current pin floats when float bit set
// R2 - Software keeps regulator current bit zero
// R3 - Mode picks input pin and division
// R4 - 12-bit programmable, 5-bit swallow counters
// R5 - New divide value acts after load
// R6 - Software writes data, then load bit
// R7 - Crystal divided to selected reference
// R8 - Up when slow, down when fast
// R9 - No requests while disabled
// R10 - Requests feed charge pump and unlock
// R11 - Error out low, high or float
// R12 - Both error pins show comparator result
// R13 - Unlock when either request active low
// R14 - Unlock flag updated each reference period
// R15 - Reading unlock register clears flag
// R16 - Software spaces unlock reads beyond period
// R17 - Direct mode loads programmable counter only
// R18 - Software splits LSB into third register
// R19 - Software may hold LSB zero
// R20 - High band swallow divides high input
// R21 - Mode codes select off/direct/swallow
// R22 - Reference codes select frequency or disable
// R23 - Divide value 17 bits over registers
// R24 - Unlock bit reads one when unlocked
// R25 - Swallow count selects higher modulus
//
// Added by the designer: the register offsets and strobed register access.
module tpd_synth (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Oscillator and crystal inputs
    input wire logic xtal_in,
    input wire logic low_band_osc_in,
    input wire logic high_band_osc_in,
    // Input amplifier enables
    output logic low_band_in_en,
    output logic high_band_in_en,
    // Comparator requests, active low
    output logic up_request_n,
    output logic down_request_n,
    // Error out pins
    output logic voltage_error_out_o,
    output logic voltage_error_out_oe,
    output logic current_error_out_o,
    output logic current_error_out_oe
);
    tpd_div_if div_bus ();

    tpd_divider u_div (
        .clk(clk),
        .rst(rst),
        .d(div_bus.div)
    );

    function automatic logic [12:0] ref_div(input logic [3:0] code);
        // Zero marks disable and prohibited codes [R22]
        case (code)
            4'h2: ref_div = tpd_pkg::TPD_DIV_5K;
            4'h3: ref_div = tpd_pkg::TPD_DIV_10K;
            4'h6: ref_div = tpd_pkg::TPD_DIV_25K;
            4'h7: ref_div = tpd_pkg::TPD_DIV_50K;
            4'h8: ref_div = tpd_pkg::TPD_DIV_3K;
            4'h9: ref_div = tpd_pkg::TPD_DIV_9K;
            4'hc: ref_div = tpd_pkg::TPD_DIV_1K;
            default: ref_div = 13'h0000;
        endcase
    endfunction

    // Pin synchronisers; edge detect reads stages two and three only
    logic [2:0] sy1, sy2, sy3;
    logic [2:0] edges;

    always_ff @(posedge clk) begin
        if (rst) begin
            sy1 <= 3'h0;
            sy2 <= 3'h0;
            sy3 <= 3'h0;
        end else begin
            sy1 <= {xtal_in, high_band_osc_in, low_band_osc_in};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    assign edges = sy2 & ~sy3;

    // Software registers
    logic [1:0] division_mode_select, next_division_mode_select;
    logic [3:0] reference_select, next_reference_select;
    logic [1:0] error_out_pin_config, next_error_out_pin_config;
    logic [7:0] divide_value_low_byte, next_divide_value_low_byte;
    logic [7:0] divide_value_high_byte, next_divide_value_high_byte;
    logic divide_value_lsb, next_divide_value_lsb;
    logic divider_load_bit, next_divider_load_bit;
    logic [15:0] divide_value_upper16;
    logic [16:0] divide_value;

    always_comb begin
        next_division_mode_select = division_mode_select;
        next_reference_select = reference_select;
        next_error_out_pin_config = error_out_pin_config;
        next_divide_value_low_byte = divide_value_low_byte;
        next_divide_value_high_byte = divide_value_high_byte;
        next_divide_value_lsb = divide_value_lsb;
        next_divider_load_bit = 1'b0;
        if (wr) begin
            if (addr == tpd_pkg::TPD_ADDR_MODE) begin
                next_division_mode_select = wdata[1:0];
            end else if (addr == tpd_pkg::TPD_ADDR_REF) begin
                next_reference_select = wdata[3:0];
            end else if (addr == tpd_pkg::TPD_ADDR_EOCFG) begin
                // Regulator bit stored only; software keeps it zero [R2]
                next_error_out_pin_config = wdata[1:0];
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_LO) begin
                next_divide_value_low_byte = wdata;
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_HI) begin
                next_divide_value_high_byte = wdata;
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_THIRD) begin
                next_divide_value_lsb = wdata[tpd_pkg::TPD_LSB_POS]; // [R23]
            end else if (addr == tpd_pkg::TPD_ADDR_LOAD) begin
                // One-cycle transfer pulse, data registers already written [R5] [R6]
                next_divider_load_bit = wdata[tpd_pkg::TPD_LOAD_POS];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            division_mode_select <= tpd_pkg::TPD_MODE_RST;
            reference_select <= tpd_pkg::TPD_REF_RST;
            error_out_pin_config <= tpd_pkg::TPD_EOCFG_RST;
            divide_value_low_byte <= tpd_pkg::TPD_BYTE_RST;
            divide_value_high_byte <= tpd_pkg::TPD_BYTE_RST;
            divide_value_lsb <= 1'b0;
            divider_load_bit <= 1'b0;
        end else begin
            division_mode_select <= next_division_mode_select;
            reference_select <= next_reference_select;
            error_out_pin_config <= next_error_out_pin_config;
            divide_value_low_byte <= next_divide_value_low_byte;
            divide_value_high_byte <= next_divide_value_high_byte;
            divide_value_lsb <= next_divide_value_lsb;
            divider_load_bit <= next_divider_load_bit;
        end
    end

    assign divide_value_upper16 = {divide_value_high_byte, divide_value_low_byte};
    assign divide_value = {divide_value_upper16, divide_value_lsb}; // [R18] [R19]

    // Mode and reference decode
    logic pll_on;
    logic mode_off;
    tpd_pkg::tpd_mode_e mode;

    assign mode = tpd_pkg::tpd_mode_e'(division_mode_select);
    assign pll_on = ref_div(reference_select) != 13'h0000; // [R22]
    assign mode_off = mode == tpd_pkg::TPD_MODE_OFF;

    // Divider hookup; programmable counter takes bits 16..5 [R4] [R21]
    assign div_bus.enable = pll_on && !mode_off;
    assign div_bus.swallow_mode = mode != tpd_pkg::TPD_MODE_DIRECT;
    assign div_bus.load = divider_load_bit;
    assign div_bus.prog_val = divide_value[16:5];
    assign div_bus.swal_val = divide_value[4:0];
    assign div_bus.in_edge = (mode == tpd_pkg::TPD_MODE_SW_HIGH) ? edges[1] : edges[0]; // [R3] [R20]

    // Reference generator on crystal edges
    logic [12:0] ref_cnt, next_ref_cnt;
    logic fr_tick, next_fr_tick;

    always_comb begin
        next_ref_cnt = ref_cnt;
        next_fr_tick = 1'b0;
        if (!pll_on) begin
            next_ref_cnt = 13'h0000;
        end else if (edges[2]) begin
            // One reference pulse per selected crystal count [R7]
            if (ref_cnt >= ref_div(reference_select) - 13'h0001) begin
                next_ref_cnt = 13'h0000;
                next_fr_tick = 1'b1;
            end else begin
                next_ref_cnt = ref_cnt + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_cnt <= 13'h0000;
            fr_tick <= 1'b0;
        end else begin
            ref_cnt <= next_ref_cnt;
            fr_tick <= next_fr_tick;
        end
    end

    // Phase comparator
    tpd_pkg::tpd_pfd_e pfd, next_pfd;

    always_comb begin
        next_pfd = pfd;
        if (!div_bus.enable) begin
            next_pfd = tpd_pkg::TPD_PFD_IDLE; // [R9]
        end else begin
            case (pfd)
                tpd_pkg::TPD_PFD_IDLE: begin
                    // Reference first means divided output is slow [R8]
                    if (fr_tick && !div_bus.fn_tick) begin
                        next_pfd = tpd_pkg::TPD_PFD_UP;
                    end else if (div_bus.fn_tick && !fr_tick) begin
                        next_pfd = tpd_pkg::TPD_PFD_DN;
                    end
                end
                tpd_pkg::TPD_PFD_UP: begin
                    if (div_bus.fn_tick) begin
                        next_pfd = tpd_pkg::TPD_PFD_IDLE;
                    end
                end
                tpd_pkg::TPD_PFD_DN: begin
                    if (fr_tick) begin
                        next_pfd = tpd_pkg::TPD_PFD_IDLE;
                    end
                end
                default: next_pfd = tpd_pkg::TPD_PFD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pfd <= tpd_pkg::TPD_PFD_IDLE;
        end else begin
            pfd <= next_pfd;
        end
    end

    // Pins, requests and charge pump, all registered
    logic next_up_n, next_dn_n;
    logic next_v_o, next_v_oe, next_c_o, next_c_oe;
    logic next_low_en, next_high_en;

    always_comb begin
        next_up_n = pfd != tpd_pkg::TPD_PFD_UP; // [R10]
        next_dn_n = pfd != tpd_pkg::TPD_PFD_DN; // [R10]
        next_low_en = pll_on && (mode == tpd_pkg::TPD_MODE_DIRECT
            || mode == tpd_pkg::TPD_MODE_SW_LOW);
        next_high_en = pll_on && mode == tpd_pkg::TPD_MODE_SW_HIGH;
        // Up drives low, down drives high, in phase floats [R11]
        next_v_o = pfd == tpd_pkg::TPD_PFD_DN;
        next_v_oe = pfd != tpd_pkg::TPD_PFD_IDLE;
        if (!pll_on) begin
            next_v_o = 1'b0;
            next_v_oe = 1'b0;
        end else if (mode_off) begin
            // Inputs floated, voltage error out held low, current pin low unless float bit set [R21]
            next_v_o = 1'b0;
            next_v_oe = 1'b1;
        end
        // Same result on both pins [R12]
        next_c_o = next_v_o;
        next_c_oe = next_v_oe && !error_out_pin_config[tpd_pkg::TPD_FLOAT_POS]; // [R1]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            up_request_n <= 1'b1;
            down_request_n <= 1'b1;
            low_band_in_en <= 1'b0;
            high_band_in_en <= 1'b0;
            voltage_error_out_o <= 1'b0;
            voltage_error_out_oe <= 1'b0;
            current_error_out_o <= 1'b0;
            current_error_out_oe <= 1'b0;
        end else begin
            up_request_n <= next_up_n;
            down_request_n <= next_dn_n;
            low_band_in_en <= next_low_en;
            high_band_in_en <= next_high_en;
            voltage_error_out_o <= next_v_o;
            voltage_error_out_oe <= next_v_oe;
            current_error_out_o <= next_c_o;
            current_error_out_oe <= next_c_oe;
        end
    end

    // Unlock detection; a set in the read cycle beats the clear
    logic seen, next_seen;
    logic unlock_flag, next_unlock_flag;
    logic unlock_rd;
    logic [7:0] next_rdata;

    assign unlock_rd = rd && addr == tpd_pkg::TPD_ADDR_UNLOCK;

    always_comb begin
        next_seen = seen || !up_request_n || !down_request_n; // [R13]
        next_unlock_flag = unlock_flag;
        if (unlock_rd) begin
            next_unlock_flag = 1'b0; // [R15]
        end
        if (fr_tick) begin
            // Sampled once per reference period [R14]
            next_seen = 1'b0;
            if (seen || !up_request_n || !down_request_n) begin
                next_unlock_flag = 1'b1;
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            if (addr == tpd_pkg::TPD_ADDR_MODE) begin
                next_rdata = {6'h00, division_mode_select};
            end else if (addr == tpd_pkg::TPD_ADDR_REF) begin
                next_rdata = {4'h0, reference_select};
            end else if (unlock_rd) begin
                next_rdata[tpd_pkg::TPD_UNLOCK_POS] = unlock_flag; // [R24]
            end else if (addr == tpd_pkg::TPD_ADDR_EOCFG) begin
                next_rdata = {6'h00, error_out_pin_config};
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_LO) begin
                next_rdata = divide_value_low_byte;
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_HI) begin
                next_rdata = divide_value_high_byte;
            end else if (addr == tpd_pkg::TPD_ADDR_DIV_THIRD) begin
                next_rdata[tpd_pkg::TPD_LSB_POS] = divide_value_lsb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            seen <= 1'b0;
            unlock_flag <= 1'b0;
            rdata <= 8'h00;
        end else begin
            seen <= next_seen;
            unlock_flag <= next_unlock_flag;
            rdata <= next_rdata;
        end
    end
endmodule
